/* File: logic/program_sequencer.sv */
// Operation
// [RQ1] 16 discrete inputs and outputs per group; counts configurable
// [RQ2] one to nine recipes, same step and group counts, own step parameters
// [RQ3] load edge rounds recipe select; out-of-range value keeps recipe
// [RQ4] loaded recipe survives warm start; cold start takes configured recipe
// [RQ5] goto edge rounds step number; out-of-range number keeps current step
// [RQ6] analog output follows track value while track command high
// [RQ7] after tracking, hold level until timed ramp or event completion
// [RQ8] sequencer reset input edge moves to step one
// [RQ9] forward edge moves up one step unless on last step
// [RQ10] back edge moves down one step unless on first step
// [RQ11] expiry of step remaining time advances to next step
// [RQ12] all inputs selected by step input mask true advances; zeros ignored
// [RQ13] hold freezes remaining time and blocks timeout and mask advance only
// [RQ14] complete flag set after last step; never passes last step
// [RQ15] network master may force step and overwrite remaining time
// [RQ16] unconnected discrete inputs count as zero for masks
// [RQ17] event-only step keeps previous level; completion jumps to end level
// [RQ18] warm start with resume keeps outputs, step and remaining time
// [RQ19] cold start clears outputs and resets the sequencer
// [RQ20] raising step or group count keeps stored step parameters
// [RQ21] step entry loads each group outputs from step output mask
// [RQ22] one event per scan: reset, goto, forward, back, timeout, match
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "program_sequencer_consts.svh"

module program_sequencer #(
	parameter int MAX_STEPS = 16,
	parameter int MAX_GROUPS = 2,
	parameter int MAX_RECIPES = 9,
	parameter int FRAC = 8,
	parameter int SCAN_CYCLES = `SCAN_TIME_NS / `CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire program_sequencer_pkg::level_t track_value_in,
	input wire logic track_command,
	input wire program_sequencer_pkg::level_t step_number_in,
	input wire logic goto_step_strobe,
	input wire logic step_forward_in,
	input wire logic step_back_in,
	input wire logic seq_reset_in,
	input wire logic hold_in,
	input wire program_sequencer_pkg::level_t recipe_select_value,
	input wire logic recipe_load_strobe,
	input wire logic [16*MAX_GROUPS-1:0] discrete_inputs,
	input wire logic [16*MAX_GROUPS-1:0] inputs_connected,
	output program_sequencer_pkg::level_t analog_out,
	output logic [16*MAX_GROUPS-1:0] discrete_outputs,
	output logic sequence_complete,
	output logic [7:0] current_step,
	output logic [3:0] current_recipe
);
	import program_sequencer_pkg::*;

	localparam int SW = (MAX_STEPS > 1) ? $clog2(MAX_STEPS) : 1;
	localparam int FIELDS = `FLD_IN_MASK + 2 * MAX_GROUPS;
	localparam int DEPTH = MAX_RECIPES * MAX_STEPS * FIELDS;
	localparam int IW = $clog2(DEPTH);
	localparam int CW = (SCAN_CYCLES > 1) ? $clog2(SCAN_CYCLES) : 1;
	localparam int E_BACK = 0;
	localparam int E_FWD = 1;
	localparam int E_GOTO = 2;
	localparam int E_RESET = 3;
	localparam int E_LOAD = 4;

	function automatic logic [IW-1:0] slot(input logic [3:0] r,
		input logic [SW-1:0] s, input int f);
		int n;
		n = ((int'(r) - 1) * MAX_STEPS + int'(s)) * FIELDS + f;
		return IW'(n);
	endfunction

	// half-up rounding of a fixed-point value to a whole number
	function automatic level_t round_num(input level_t v);
		logic signed [16:0] s;
		s = 17'(v) + (17'sd1 <<< (FRAC - 1));
		return level_t'(s >>> FRAC);
	endfunction

	// move an equal share of the distance left each scan; divider is costly
	// but keeps the ramp linear even after a remaining-time overwrite
	function automatic level_t ramp(input level_t cur, input level_t fin,
		input word_t left);
		logic signed [17:0] diff;
		diff = 18'(fin) - 18'(cur);
		return level_t'(18'(cur) + diff / $signed({2'b00, left}));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic [SW-1:0] step_q;
	logic [7:0] step_num_q;
	logic [3:0] recipe_q;
	word_t remaining_q;
	level_t analog_q;
	logic [16*MAX_GROUPS-1:0] dout_q;
	logic complete_q;
	logic [31:0] ctrl_q;
	logic [31:0] psel_q;
	logic net_pend_q;
	logic [SW-1:0] net_target_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [CW-1:0] scan_cnt_q;
	logic tick_q;
	logic [4:0] cmd_prev_q;
	// parameters are not cleared by count changes, so raising counts keeps them
	word_t param_mem [DEPTH];

	////////////////////////////////////////////////////////////////////////
	// configuration and decode

	logic [7:0] steps_eff;
	logic [3:0] groups_eff;
	logic [3:0] recipes_eff;
	logic [SW-1:0] last_step;
	logic [3:0] cfg_recipe;
	logic wr_fire;
	logic ctrl_wr;
	logic cold_cmd;
	logic restart;
	logic net_time_wr;
	logic [3:0] rec_after;
	logic [4:0] cmd_now;
	logic [4:0] edge_hit;

	always_comb
	begin
		steps_eff = ctrl_q[`CTRL_STEPS_LSB +: 8];
		if (steps_eff == 8'h00)
			steps_eff = 8'h01;
		else if (steps_eff > 8'(MAX_STEPS))
			steps_eff = 8'(MAX_STEPS);
		groups_eff = ctrl_q[`CTRL_GROUPS_LSB +: 4];
		if (groups_eff > 4'(MAX_GROUPS))
			groups_eff = 4'(MAX_GROUPS);
		recipes_eff = ctrl_q[`CTRL_RECIPES_LSB +: 4];
		if (recipes_eff == 4'h0)
			recipes_eff = 4'h1;
		else if (recipes_eff > 4'(MAX_RECIPES))
			recipes_eff = 4'(MAX_RECIPES);
		cfg_recipe = ctrl_q[`CTRL_CFGREC_LSB +: 4];
		if (cfg_recipe == 4'h0 || cfg_recipe > recipes_eff)
			cfg_recipe = 4'h1;
	end

	assign last_step = SW'(steps_eff - 8'h01);
	assign wr_fire = avs_write && !wait_q && avs_byteenable == 4'hF;
	assign ctrl_wr = wr_fire && avs_address == `REG_CTRL;
	// [RQ19] cold start decode
	assign cold_cmd = ctrl_wr && avs_writedata[`CTRL_COLD_BIT];
	// [RQ18] warm start resumes unless resume is off
	assign restart = cold_cmd || (ctrl_wr && avs_writedata[`CTRL_WARM_BIT]
		&& !ctrl_q[`CTRL_RESUME_BIT]);
	assign net_time_wr = wr_fire && avs_address == `REG_NET_TIME;
	assign rec_after = cold_cmd ? cfg_recipe : recipe_q;
	assign cmd_now = {recipe_load_strobe, seq_reset_in, goto_step_strobe,
		step_forward_in, step_back_in};
	assign edge_hit = tick_q ? (cmd_now & ~cmd_prev_q) : 5'h00;

	////////////////////////////////////////////////////////////////////////
	// scan cycle

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			scan_cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else if (scan_cnt_q == CW'(SCAN_CYCLES - 1))
		begin
			scan_cnt_q <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			scan_cnt_q <= scan_cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			cmd_prev_q <= 5'h00;
		else if (tick_q)
			cmd_prev_q <= cmd_now;
	end

	////////////////////////////////////////////////////////////////////////
	// step evaluation

	word_t time_cur;
	level_t end_cur;
	level_t goto_num;
	level_t rec_num;
	logic goto_ok;
	logic rec_ok;
	logic timed_out;
	logic match;
	step_event_t ev;
	logic [SW-1:0] target;
	logic enter;
	logic finish;
	logic [16*MAX_GROUPS-1:0] dout_next;

	assign time_cur = param_mem[slot(recipe_q, step_q, `FLD_TIME)];
	assign end_cur = param_mem[slot(recipe_q, step_q, `FLD_LEVEL)];
	assign goto_num = round_num(step_number_in);
	assign rec_num = round_num(recipe_select_value);
	assign goto_ok = goto_num >= 16'sd1
		&& goto_num <= level_t'({8'h00, steps_eff});
	assign rec_ok = rec_num >= 16'sd1
		&& rec_num <= level_t'({12'h000, recipes_eff});
	// [RQ11] remaining time runs out this scan
	assign timed_out = time_cur != 16'h0000 && remaining_q <= 16'h0001;

	always_comb
	begin
		match = groups_eff != 4'h0;
		for (int g = 0; g < MAX_GROUPS; g++)
		begin
			// [RQ12] masked inputs all true
			// [RQ16] unconnected reads zero
			if (g < int'(groups_eff) && ((discrete_inputs[16*g +: 16]
				& inputs_connected[16*g +: 16]
				& param_mem[slot(recipe_q, step_q, `FLD_IN_MASK + g)])
				!= param_mem[slot(recipe_q, step_q, `FLD_IN_MASK + g)]))
				match = 1'b0;
		end
	end

	// [RQ22] one event per scan
	always_comb
	begin
		ev = EV_NONE;
		target = step_q;
		enter = 1'b0;
		if (tick_q)
		begin
			// [RQ8] reset to step one
			if (edge_hit[E_RESET])
			begin
				ev = EV_RESET;
				target = '0;
				enter = 1'b1;
			end
			else if (net_pend_q)
			begin
				ev = EV_NET;
				target = net_target_q;
				enter = 1'b1;
			end
			// [RQ5] rounded goto in range
			else if (edge_hit[E_GOTO])
			begin
				ev = EV_GOTO;
				target = SW'(goto_num - 16'sd1);
				enter = goto_ok;
			end
			// [RQ9] forward unless last
			else if (edge_hit[E_FWD])
			begin
				ev = EV_FORWARD;
				target = SW'(step_q + 1'b1);
				enter = step_q != last_step;
			end
			// [RQ10] back unless first
			else if (edge_hit[E_BACK])
			begin
				ev = EV_BACK;
				target = SW'(step_q - 1'b1);
				enter = step_q != '0;
			end
			// [RQ13] hold blocks automatic advance
			else if (!hold_in && !complete_q && (timed_out || match))
			begin
				ev = timed_out ? EV_TIMEOUT : EV_MATCH;
				target = SW'(step_q + 1'b1);
				enter = step_q != last_step;
			end
		end
		if (!enter)
			target = step_q;
	end

	always_comb
	begin
		unique case (ev)
			EV_TIMEOUT, EV_MATCH:
				finish = 1'b1;
			EV_NONE, EV_RESET, EV_NET, EV_GOTO, EV_FORWARD, EV_BACK:
				finish = 1'b0;
		endcase
	end

	always_comb
	begin
		dout_next = '0;
		for (int g = 0; g < MAX_GROUPS; g++)
		begin
			if (g < int'(groups_eff))
				dout_next[16*g +: 16] = param_mem[slot(recipe_q, target,
					`FLD_IN_MASK + MAX_GROUPS + g)];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer state

	always_ff @(posedge clk)
	begin
		if (!reset_n || restart)
			step_q <= '0;
		else if (enter)
			step_q <= target;
	end

	// one-based step number kept in its own register for the output pin
	always_ff @(posedge clk)
	begin
		if (!reset_n || restart)
			step_num_q <= 8'h01;
		else if (enter)
			step_num_q <= 8'(target) + 8'h01;
	end

	// [RQ14] complete after last step
	always_ff @(posedge clk)
	begin
		if (!reset_n || restart || enter)
			complete_q <= 1'b0;
		else if (finish && step_q == last_step)
			complete_q <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			remaining_q <= 16'h0000;
		else if (restart)
			remaining_q <= param_mem[slot(rec_after, '0, `FLD_TIME)];
		// [RQ15] network overwrite of time
		else if (net_time_wr)
			remaining_q <= avs_writedata[15:0];
		else if (enter)
			remaining_q <= param_mem[slot(recipe_q, target, `FLD_TIME)];
		// [RQ13] hold freezes time
		else if (tick_q && !hold_in && !complete_q && !timed_out
			&& time_cur != 16'h0000)
			remaining_q <= remaining_q - 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n || restart)
			analog_q <= 16'sh0000;
		// [RQ6] follow track value
		else if (track_command)
			analog_q <= track_value_in;
		// [RQ17] completion jumps to end level
		else if (finish)
			analog_q <= end_cur;
		// [RQ7] tracked level ramps only in a timed step
		else if (tick_q && ev == EV_NONE && !hold_in && !complete_q
			&& time_cur != 16'h0000)
			analog_q <= ramp(analog_q, end_cur, remaining_q);
	end

	// [RQ21] outputs from step output mask
	always_ff @(posedge clk)
	begin
		if (!reset_n || restart)
			dout_q <= '0;
		else if (enter)
			dout_q <= dout_next;
	end

	// [RQ4] recipe kept unless cold start
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			recipe_q <= `RECIPE_RESET_VAL;
		else if (cold_cmd)
			recipe_q <= cfg_recipe;
		// [RQ3] rounded in-range recipe load
		else if (edge_hit[E_LOAD] && rec_ok)
			recipe_q <= rec_num[3:0];
	end

	////////////////////////////////////////////////////////////////////////
	// register bus

	logic [3:0] psel_rec;
	logic [7:0] psel_step;
	logic [7:0] psel_fld;
	logic psel_ok;
	logic [31:0] rdata_d;
	logic [SW-1:0] net_req;
	level_t net_num;

	assign psel_rec = psel_q[`PSEL_RECIPE_LSB +: 4];
	assign psel_step = psel_q[`PSEL_STEP_LSB +: 8];
	assign psel_fld = psel_q[7:0];
	// [RQ2] parameter space for every recipe
	assign psel_ok = psel_rec >= 4'h1 && psel_rec <= 4'(MAX_RECIPES)
		&& psel_step < 8'(MAX_STEPS) && psel_fld < 8'(FIELDS);
	assign net_num = level_t'(avs_writedata[15:0]);
	assign net_req = SW'(net_num - 16'sd1);

	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (avs_address)
			`REG_CTRL:
				rdata_d = ctrl_q;
			`REG_STATUS:
			begin
				rdata_d[7:0] = 8'(step_q) + 8'h01;
				rdata_d[`STAT_RECIPE_LSB +: 4] = recipe_q;
				rdata_d[`STAT_COMPLETE_BIT] = complete_q;
			end
			`REG_NET_STEP:
				rdata_d[7:0] = 8'(step_q) + 8'h01;
			`REG_NET_TIME:
				rdata_d[15:0] = remaining_q;
			`REG_PSEL:
				rdata_d = psel_q;
			`REG_PDATA:
				if (psel_ok)
					rdata_d[15:0] = param_mem[slot(psel_rec,
						SW'(psel_step), int'(psel_fld))];
			default:
				rdata_d = 32'h0000_0000;
		endcase
	end

	// one wait cycle on every request, then the answer
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			wait_q <= 1'b1;
		else if ((avs_read || avs_write) && wait_q)
			wait_q <= 1'b0;
		else
			wait_q <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			rdata_q <= 32'h0000_0000;
		else if (avs_read && wait_q)
			rdata_q <= rdata_d;
	end

	// [RQ1] group and step counts set here
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			ctrl_q <= `CTRL_RESET_VAL;
		else if (ctrl_wr)
			ctrl_q <= avs_writedata & `CTRL_KEEP_MASK;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			psel_q <= 32'h0000_0000;
		else if (wr_fire && avs_address == `REG_PSEL)
			psel_q <= avs_writedata & `PSEL_KEEP_MASK;
	end

	// [RQ15] network step force; new write wins over the scan taking it
	always_ff @(posedge clk)
	begin
		if (!reset_n || restart)
			net_pend_q <= 1'b0;
		else if (wr_fire && avs_address == `REG_NET_STEP && net_num >= 16'sd1
			&& net_num <= level_t'({8'h00, steps_eff}))
			net_pend_q <= 1'b1;
		else if (ev == EV_NET)
			net_pend_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			net_target_q <= '0;
		else if (wr_fire && avs_address == `REG_NET_STEP)
			net_target_q <= net_req;
	end

	// [RQ20] counts never clear stored parameters
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				param_mem[i] <= 16'h0000;
		end
		else if (wr_fire && avs_address == `REG_PDATA && psel_ok)
			param_mem[slot(psel_rec, SW'(psel_step), int'(psel_fld))]
				<= avs_writedata[15:0];
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign analog_out = analog_q;
	assign discrete_outputs = dout_q;
	assign sequence_complete = complete_q;
	assign current_step = step_num_q;
	assign current_recipe = recipe_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_fwd_at_last;
		ev == EV_FORWARD && step_q == last_step && !restart;
	endsequence

	sequence s_mid_match;
		ev == EV_MATCH && step_q != last_step && !restart;
	endsequence

	a_track_follow: assert property ( // [RQ6]
		track_command && !restart |=> analog_q == $past(track_value_in))
		else $error("analog output not tracking");
	a_reset_step1: assert property ( // [RQ8]
		edge_hit[E_RESET] |=> step_q == '0 && !complete_q)
		else $error("reset did not reach step one");
	a_fwd_last: assert property ( // [RQ9]
		s_fwd_at_last |=> $stable(step_q))
		else $error("forward moved past last step");
	a_back_first: assert property ( // [RQ10]
		ev == EV_BACK && step_q == '0 && !restart |=> step_q == '0)
		else $error("back moved below first step");
	a_hold_time: assert property ( // [RQ13]
		tick_q && hold_in && !enter && !restart && !net_time_wr
		|=> $stable(remaining_q) ##1 !tick_q)
		else $error("hold did not freeze time");
	a_complete_stay: assert property ( // [RQ14]
		complete_q && !enter && !restart |=> complete_q && $stable(step_q))
		else $error("sequencer left completed last step");
	a_goto_bad: assert property ( // [RQ5]
		ev == EV_GOTO && !goto_ok && !restart |=> $stable(step_q))
		else $error("bad goto changed step");
	a_recipe_bad: assert property ( // [RQ3]
		edge_hit[E_LOAD] && !rec_ok && !cold_cmd |=> $stable(recipe_q))
		else $error("bad recipe load changed recipe");
	a_mask_advance: assert property ( // [RQ12]
		s_mid_match |=> step_q == SW'($past(step_q) + 1'b1))
		else $error("mask match did not advance");
	a_event_level: assert property ( // [RQ17]
		finish && !track_command && !restart |=> analog_q == $past(end_cur))
		else $error("completion level wrong");

endmodule // program_sequencer

`default_nettype wire

/* File: logic/program_sequencer_consts.svh */
`ifndef PROGRAM_SEQUENCER_CONSTS_SVH
`define PROGRAM_SEQUENCER_CONSTS_SVH

// timing
`define CLK_PERIOD_NS 8
`define SCAN_TIME_NS 100000

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_NET_STEP 8'h08
`define REG_NET_TIME 8'h0C
`define REG_PSEL 8'h10
`define REG_PDATA 8'h14

// control fields
`define CTRL_COLD_BIT 0
`define CTRL_WARM_BIT 1
`define CTRL_RESUME_BIT 2
`define CTRL_STEPS_LSB 8
`define CTRL_GROUPS_LSB 16
`define CTRL_RECIPES_LSB 20
`define CTRL_CFGREC_LSB 24
`define CTRL_KEEP_MASK 32'h0FFF_FF04
`define CTRL_RESET_VAL 32'h0111_0400
`define RECIPE_RESET_VAL 4'h1

// status fields
`define STAT_RECIPE_LSB 8
`define STAT_COMPLETE_BIT 16

// parameter window select fields
`define PSEL_STEP_LSB 8
`define PSEL_RECIPE_LSB 16
`define PSEL_KEEP_MASK 32'h000F_FFFF

// per-step parameter slots
`define FLD_TIME 0
`define FLD_LEVEL 1
`define FLD_IN_MASK 2

`endif

/* File: logic/program_sequencer_pkg.sv */
`default_nettype none

package program_sequencer_pkg;

	typedef logic signed [15:0] level_t;
	typedef logic [15:0] word_t;

	typedef enum logic [2:0] {
		EV_NONE,
		EV_RESET,
		EV_NET,
		EV_GOTO,
		EV_FORWARD,
		EV_BACK,
		EV_TIMEOUT,
		EV_MATCH
	} step_event_t;

endpackage

`default_nettype wire

/* File: tb/field_blocks_model.sv */
`timescale 1ns/100ps
`default_nettype none

module field_blocks_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [31:0] level_bits,
	input wire logic [31:0] link_bits,
	output logic [31:0] discrete_inputs,
	output logic [31:0] inputs_connected
);
	logic [31:0] noise_q;

	////////////////////////////////////////////////////////////////////////
	// open bits churn
	// an unwired input never shows a settled level, so a design that
	// forgets the connected flags will see ones sooner or later
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			noise_q <= 32'h5A5A_5A5A;
		else
			noise_q <= ~noise_q;
	end

	always_comb
	begin
		inputs_connected = link_bits;
		discrete_inputs = (level_bits & link_bits) | (noise_q & ~link_bits);
	end
endmodule // field_blocks_model

`default_nettype wire

/* File: tb/program_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "program_sequencer_consts.svh"

module program_sequencer_tb;
	import program_sequencer_pkg::*;
	// short scan keeps the run brief; waits below are in scans except the cycle counts in bus, pulse, wait_step, t_timed, t_track, the reset hold and watchdog
	localparam int SCAN = 8;
	localparam logic [31:0] CTRL_G0 = 32'h0120_0400;
	localparam logic [31:0] CTRL_G1 = 32'h0121_0400;
	logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	level_t track_value_in, step_number_in, recipe_select_value, analog_out;
	logic track_command, hold_in, complete;
	logic [4:0] cmd;
	logic [31:0] level_bits, link_bits, din, dconn, dout;
	logic [7:0] cur_step;
	logic [3:0] cur_rec;
	int num_errors, n_tests;

	program_sequencer #(.SCAN_CYCLES(SCAN)) u_dut (
		.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.track_value_in(track_value_in), .track_command(track_command),
		.step_number_in(step_number_in), .goto_step_strobe(cmd[0]),
		.step_forward_in(cmd[1]), .step_back_in(cmd[2]),
		.seq_reset_in(cmd[3]), .hold_in(hold_in),
		.recipe_select_value(recipe_select_value),
		.recipe_load_strobe(cmd[4]), .discrete_inputs(din),
		.inputs_connected(dconn), .analog_out(analog_out),
		.discrete_outputs(dout), .sequence_complete(complete),
		.current_step(cur_step), .current_recipe(cur_rec)
	);

	field_blocks_model u_far (
		.clk(clk), .reset_n(reset_n), .level_bits(level_bits),
		.link_bits(link_bits), .discrete_inputs(din),
		.inputs_connected(dconn)
	);

	////////////////////////////////////////////////////////////////////////
	task give_verdict;
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
			num_errors++;
		end
	endtask

	// request held until waitrequest is sampled low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 50)
			chk(32'h0, 32'h1, "bus hang");
	endtask

	task scans(input int k);
		repeat (k * SCAN) @(posedge clk);
	endtask

	// strobes stay high and low for two scans each, so every edge is seen
	task pulse(input logic [4:0] m);
		@(posedge clk);
		cmd <= m;
		scans(2);
		cmd <= 5'h00;
		scans(2);
	endtask

	task wait_step(input logic [7:0] s);
		int n;
		n = 0;
		while (cur_step !== s && n < 60)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(cur_step), 32'(s), "step wait");
	endtask

	task param(input int r, input int s, input int f, input logic [15:0] v);
		bus(1'b1, `REG_PSEL, 32'(f) | 32'(s) << 8 | 32'(r) << 16, 4'hF);
		bus(1'b1, `REG_PDATA, {16'h0, v}, 4'hF);
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		chk(32'(cur_step), 32'h1, "reset step");
		chk(32'(analog_out) | dout, 32'h0, "reset outputs");
		chk(32'(complete), 32'h0, "reset complete");
		bus(1'b0, `REG_CTRL, 32'h0, 4'hF);
		chk(rd, `CTRL_RESET_VAL, "ctrl reset value");
		bus(1'b0, 8'h02, 32'h0, 4'hF);
		chk(rd, 32'h0, "unmapped read");
	endtask

	task t_moves;
		bus(1'b1, `REG_CTRL, CTRL_G0, 4'hF);
		hold_in <= 1'b1;
		pulse(5'h08);
		for (int i = 2; i <= 5; i++)
		begin
			pulse(5'h02);
			chk(32'(cur_step), (i > 4) ? 4 : i, "forward");
		end
		pulse(5'h04);
		chk(32'(cur_step), 32'h3, "back");
		step_number_in <= 16'h0180;
		pulse(5'h01);
		chk(32'(cur_step), 32'h2, "goto rounded");
		step_number_in <= 16'h0500;
		pulse(5'h01);
		chk(32'(cur_step), 32'h2, "goto out of range");
		pulse(5'h08);
		chk(32'(cur_step), 32'h1, "seq reset");
		pulse(5'h04);
		chk(32'(cur_step), 32'h1, "back on first");
	endtask

	task t_timed;
		int n;
		bus(1'b1, `REG_CTRL, CTRL_G1, 4'hF);
		param(1, 0, 0, 16'h0002);
		param(1, 0, 1, 16'h0400);
		param(1, 0, 2, 16'h0001);
		param(1, 0, 4, 16'h00A5);
		param(1, 1, 1, 16'h0200);
		param(1, 1, 2, 16'h0003);
		param(1, 1, 4, 16'h0F00);
		param(2, 0, 1, 16'h0700);
		bus(1'b1, `REG_PSEL, 32'h0001_0001, 4'hF);
		bus(1'b0, `REG_PDATA, 32'h0, 4'hF);
		chk(rd, 32'h0400, "recipe one level");
		pulse(5'h08);
		chk(dout & 32'hFFFF, 32'h00A5, "step one outputs");
		hold_in <= 1'b0;
		repeat (7) @(posedge clk);
		chk(32'(cur_step), 32'h1, "early advance");
		wait_step(8'h2);
		chk(32'(analog_out), 32'h0400, "ramp end level");
		chk(dout & 32'hFFFF, 32'h0F00, "step two outputs");
		level_bits <= 32'h3;
		link_bits <= 32'h1;
		scans(3);
		chk(32'(cur_step), 32'h2, "open input");
		chk(32'(analog_out), 32'h0400, "event step level");
		hold_in <= 1'b1;
		link_bits <= 32'h3;
		scans(3);
		chk(32'(cur_step), 32'h2, "hold blocks match");
		hold_in <= 1'b0;
		wait_step(8'h3);
		chk(32'(analog_out), 32'h0200, "event end level");
		n = 0;
		while (complete !== 1'b1 && n < 60)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(complete), 32'h1, "complete");
		scans(3);
		chk(32'(cur_step), 32'h4, "stay on last");
	endtask

	task t_net;
		hold_in <= 1'b1;
		link_bits <= 32'h0;
		bus(1'b1, `REG_NET_STEP, 32'h2, 4'hF);
		scans(2);
		chk(32'(cur_step), 32'h2, "net step");
		chk(32'(complete), 32'h0, "complete cleared");
		bus(1'b1, `REG_NET_TIME, 32'h5, 4'hF);
		bus(1'b0, `REG_NET_TIME, 32'h0, 4'hF);
		chk(rd, 32'h5, "net time");
		bus(1'b1, `REG_NET_TIME, 32'h9, 4'h3);
		bus(1'b0, `REG_NET_TIME, 32'h0, 4'hF);
		chk(rd, 32'h5, "partial write");
		bus(1'b0, `REG_STATUS, 32'h0, 4'hF);
		chk(rd, 32'h0000_0102, "status");
		// resume must already be stored when the warm start arrives
		bus(1'b1, `REG_CTRL, CTRL_G1 | 32'h4, 4'hF);
		bus(1'b1, `REG_CTRL, CTRL_G1 | 32'h6, 4'hF);
		scans(1);
		bus(1'b0, `REG_NET_TIME, 32'h0, 4'hF);
		chk(rd, 32'h5, "resume time");
		chk(32'(cur_step) | dout, 32'h0F02, "resume step outputs");
		bus(1'b1, `REG_CTRL, CTRL_G1, 4'hF);
	endtask

	task t_track;
		track_value_in <= 16'h1234;
		track_command <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(analog_out), 32'h1234, "track");
		track_value_in <= 16'h0F0F;
		repeat (3) @(posedge clk);
		chk(32'(analog_out), 32'h0F0F, "track follow");
		track_command <= 1'b0;
		scans(2);
		chk(32'(analog_out), 32'h0F0F, "track held");
	endtask

	task t_recipe;
		recipe_select_value <= 16'h0180;
		pulse(5'h10);
		chk(32'(cur_rec), 32'h2, "recipe rounded");
		recipe_select_value <= 16'h0380;
		pulse(5'h10);
		chk(32'(cur_rec), 32'h2, "recipe out of range");
		bus(1'b1, `REG_CTRL, CTRL_G1 | 32'h2, 4'hF);
		scans(1);
		chk(32'(cur_rec), 32'h2, "warm keeps recipe");
		chk(32'(cur_step), 32'h1, "warm without resume");
		bus(1'b1, `REG_CTRL, CTRL_G1 | 32'h1, 4'hF);
		scans(1);
		chk(32'(cur_rec), 32'h1, "cold recipe");
		chk(32'(analog_out) | dout, 32'h0, "cold outputs");
		chk(32'(cur_step), 32'h1, "cold step");
		bus(1'b1, `REG_CTRL, CTRL_G1 | 32'h0800, 4'hF);
		bus(1'b1, `REG_PSEL, 32'h0002_0001, 4'hF);
		bus(1'b0, `REG_PDATA, 32'h0, 4'hF);
		chk(rd, 32'h0700, "params kept");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict;
	end

	initial
	begin
		num_errors = 0;
		n_tests = 0;
		reset_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		track_value_in = 16'h0000;
		step_number_in = 16'h0000;
		recipe_select_value = 16'h0000;
		track_command = 1'b0;
		hold_in = 1'b0;
		cmd = 5'h00;
		level_bits = 32'h0;
		link_bits = 32'h0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		t_reset;
		t_moves;
		t_timed;
		t_net;
		t_track;
		t_recipe;
		give_verdict;
	end
endmodule // program_sequencer_tb

`default_nettype wire
